/* logic/vliw_pkg.sv */
`default_nettype none
package vliw_pkg;
    localparam int SLOTS     = 8;
    localparam int INSTR_W   = 32;
    localparam int PKT_W     = 256;
    localparam int REGS      = 16;
    localparam int REG_W     = 32;
    localparam int IDX_W     = 4;
    localparam int PTR_W     = 3;
    localparam int DW_W      = 64;
    localparam int BE_W      = 4;
    localparam int SIDES     = 2;
    localparam int ALIGN_W   = 5;
    localparam logic [31:0] FETCH_BYTES = 32'h0000_0020;
    // instruction fields
    localparam int CHAIN_BIT = 0;
    localparam int CROSS_BIT = 1;
    localparam int UNIT_LSB  = 2;
    localparam int SIDE_BIT  = 2;
    localparam int CLASS_LSB = 5;
    localparam int SIZE_LSB  = 7;
    localparam int CIRC_BIT  = 9;
    localparam int LONG_BIT  = 10;
    localparam int DST_LSB   = 11;
    localparam int SRC2_LSB  = 15;
    localparam int SRC1_LSB  = 19;
    localparam int OFF5_LSB  = 23;
    localparam int OFF5_W    = 5;
    localparam int LHI_LSB   = 15;
    localparam int LHI_W     = 13;
    localparam int LLO_W     = 2;
    localparam int Z_BIT     = 28;
    localparam int CREG_LSB  = 29;
    localparam int CREG_W    = 3;
    localparam logic [3:0] LONG_BASE = 4'hF;
    localparam logic [3:0] PAIR_MASK = 4'h1;
    localparam logic [2:0] CREG_NONE = 3'h0;
    localparam logic [2:0] CREG_A1   = 3'h1;
    localparam logic [2:0] CREG_A2   = 3'h2;
    localparam logic [2:0] CREG_B0   = 3'h3;
    localparam logic [2:0] CREG_B1   = 3'h4;
    localparam logic [2:0] CREG_B2   = 3'h5;
    localparam logic [3:0] BE_BYTE   = 4'h1;
    localparam logic [3:0] BE_HALF   = 4'h3;
    localparam logic [3:0] BE_WORD   = 4'hF;
    typedef enum logic [2:0] {
        logic_unit_side_a    = 3'h0, shift_unit_side_a = 3'h1,
        multiply_unit_side_a = 3'h2, data_unit_side_a  = 3'h3,
        logic_unit_side_b    = 3'h4, shift_unit_side_b = 3'h5,
        multiply_unit_side_b = 3'h6, data_unit_side_b  = 3'h7
    } unit_t;
    typedef enum logic [1:0] {
        cls_alu = 2'h0, cls_fp = 2'h1, cls_mul = 2'h2, cls_mem = 2'h3
    } class_t;
    typedef enum logic [1:0] {
        sz_byte = 2'h0, sz_half = 2'h1, sz_word = 2'h2,
        double_word_load = 2'h3
    } size_t;
    typedef enum logic [1:0] {
        st_fetch = 2'h0, st_wait = 2'h1, st_issue = 2'h3
    } state_t;
endpackage : vliw_pkg
`default_nettype wire

/* logic/vliw_fetch_dispatch.sv */
`timescale 1ns/1ns
`default_nettype none
// Function
// - each fetch brings one 256-bit packet of eight 32-bit slots
// - lsb 1 chains the next slot into the same execute packet
// - lsb 0 ends the execute packet; next slot issues later
// - an execute packet holds one to eight instructions on distinct units
// - a fetch packet may hold one to eight execute packets
// - at most one execute packet is issued per clock
// - next fetch waits until all execute packets are dispatched
// - packets never span fetch packets; pad slots issue as members
// - two register files, sixteen 32-bit registers per side
// - side a units numbered one, side b units numbered two
// - all four units of a side read that side in one cycle
// - one cross-path read and one cross-path write per side per cycle
// - logic, multiply, data units take floating point; shift units not
// - shift units carry the double-word load, 64 bits per side
// - only data units access memory; data may use the other file
// - linear or circular addressing with 5- or 15-bit offsets
// - each instruction may be conditional on a condition register; creg 0 is unconditional
// - multiply units only multiply or take floating point; no other unit multiplies
// - byte, half-word and word memory access
// - both multiply units may issue every clock
module vliw_fetch_dispatch #(
    parameter logic [31:0] RESET_PC  = 32'h0000_0000,
    parameter int          CIRC_BITS = 8
) (
    input  wire logic           core_clk,
    input  wire logic           rst,
    output var  logic           fetch_req,
    output var  logic [31:0]    fetch_addr,
    input  wire logic           fetch_valid,
    input  wire logic [255:0]   fetch_data,
    output var  logic           pkt_issued,
    output var  logic [7:0]     issue_valid,
    output var  logic [255:0]   issue_instr,
    output var  logic [255:0]   issue_opa,
    output var  logic [255:0]   issue_opb,
    output var  logic           decode_error,
    output var  logic [1:0]     mem_req,
    output var  logic [63:0]    mem_addr,
    output var  logic [7:0]     mem_be,
    output var  logic [1:0]     mem_dword,
    output var  logic [1:0]     mem_xside,
    input  wire logic [7:0]     wb_en,
    input  wire logic [31:0]    wb_dst,
    input  wire logic [7:0]     wb_xside,
    input  wire logic [7:0]     wb_pair,
    input  wire logic [511:0]   wb_data,
    output var  logic           wb_dropped
);
    localparam int SLOTS = vliw_pkg::SLOTS;
    localparam int RW    = vliw_pkg::REG_W;
    localparam int IW    = vliw_pkg::IDX_W;
    localparam int PTR_W = vliw_pkg::PTR_W;

    if (CIRC_BITS < 2 || CIRC_BITS > 31) begin : g_bad_circ
        $error("CIRC_BITS must lie in 2..31");
    end
    if (RESET_PC[vliw_pkg::ALIGN_W-1:0] != '0) begin : g_bad_pc
        $error("RESET_PC must be fetch-packet aligned");
    end

    vliw_pkg::state_t                 state_reg, state_next;
    logic [31:0]                      pc_reg, pc_next;
    logic [vliw_pkg::PTR_W-1:0]       ptr_reg, ptr_next, last;
    logic [SLOTS-1:0][31:0]           pkt_reg, pkt_next;
    logic                             fetch_req_reg, fetch_req_next;
    logic [SLOTS-1:0]                 in_pkt;
    logic                             ended;
    logic                             pi_reg, pi_next;
    logic [SLOTS-1:0]                 iv_reg, iv_next, taken;
    logic [SLOTS-1:0][31:0]           ii_reg, ii_next;
    logic [SLOTS-1:0][RW-1:0]         oa_reg, oa_next, ob_reg, ob_next;
    logic                             err_reg, err_next;
    logic [1:0]                       mr_reg, mr_next, xrd;
    logic [1:0][31:0]                 ma_reg, ma_next;
    logic [1:0][3:0]                  mb_reg, mb_next;
    logic [1:0]                       md_reg, md_next, mx_reg, mx_next;
    logic [RW-1:0]                    rf_a_reg [vliw_pkg::REGS];
    logic [RW-1:0]                    rf_b_reg [vliw_pkg::REGS];
    logic [RW-1:0]                    rfa_next [vliw_pkg::REGS];
    logic [RW-1:0]                    rfb_next [vliw_pkg::REGS];
    logic                             drop_reg, drop_next;
    logic [1:0]                       xw;
    logic [31:0]                      w, cv, s1v, s2v, ba, ea;
    vliw_pkg::unit_t                  u;
    logic [5:0]                       cm;
    logic                             sd, xs, ok, pass;
    logic [2:0]                       uu;
    logic                             us, ds, pr;
    logic [IW-1:0]                    wd;

    function automatic logic is_long(input logic [31:0] x);
        return vliw_pkg::class_t'(x[vliw_pkg::CLASS_LSB +: 2])
               == vliw_pkg::cls_mem && x[vliw_pkg::LONG_BIT];
    endfunction : is_long

    // long form implies the data unit of the side bit
    function automatic vliw_pkg::unit_t unit_of(input logic [31:0] x);
        logic [2:0] v;
        v = x[vliw_pkg::UNIT_LSB +: 3];
        if (is_long(x))
            return v[vliw_pkg::SIDE_BIT] ? vliw_pkg::data_unit_side_b
                                         : vliw_pkg::data_unit_side_a;
        return vliw_pkg::unit_t'(v);
    endfunction : unit_of

    function automatic logic legal(input logic [31:0] x);
        vliw_pkg::unit_t v;
        vliw_pkg::class_t c;
        logic sh, mu, da;
        v  = unit_of(x);
        c  = vliw_pkg::class_t'(x[vliw_pkg::CLASS_LSB +: 2]);
        sh = v == vliw_pkg::shift_unit_side_a ||
             v == vliw_pkg::shift_unit_side_b;
        mu = v == vliw_pkg::multiply_unit_side_a ||
             v == vliw_pkg::multiply_unit_side_b;
        da = v == vliw_pkg::data_unit_side_a ||
             v == vliw_pkg::data_unit_side_b;
        if (x[vliw_pkg::CREG_LSB +: 3] > vliw_pkg::CREG_B2)
            return 1'h0;
        if (c == vliw_pkg::cls_fp && sh)
            return 1'h0;
        if (mu != (c == vliw_pkg::cls_mul) && !(mu && c == vliw_pkg::cls_fp))
            return 1'h0;
        return c != vliw_pkg::cls_mem || da;
    endfunction : legal

    // {unconditional, side, index}
    function automatic logic [5:0] creg_map(input logic [2:0] c);
        case (c)
            vliw_pkg::CREG_A1: return {1'h0, 1'h0, 4'h1};
            vliw_pkg::CREG_A2: return {1'h0, 1'h0, 4'h2};
            vliw_pkg::CREG_B0: return {1'h0, 1'h1, 4'h0};
            vliw_pkg::CREG_B1: return {1'h0, 1'h1, 4'h1};
            vliw_pkg::CREG_B2: return {1'h0, 1'h1, 4'h2};
            default:           return {1'h1, 1'h0, 4'h0};
        endcase
    endfunction : creg_map

    function automatic logic [31:0] addr_of(input logic [31:0] x,
                                            input logic [31:0] base);
        logic [31:0] off, sum, mask;
        off = is_long(x)
            ? {17'h0, x[vliw_pkg::LHI_LSB +: vliw_pkg::LHI_W],
               x[vliw_pkg::UNIT_LSB +: vliw_pkg::LLO_W]}
            : {27'h0, x[vliw_pkg::OFF5_LSB +: vliw_pkg::OFF5_W]};
        off  = off << x[vliw_pkg::SIZE_LSB +: 2];
        sum  = base + off;
        mask = (32'h1 << CIRC_BITS) - 32'h1;
        return x[vliw_pkg::CIRC_BIT] ? ((base & ~mask) | (sum & mask))
                                     : sum;
    endfunction : addr_of

    function automatic logic [3:0] be_of(input logic [31:0] x,
                                         input logic [1:0] a);
        case (vliw_pkg::size_t'(x[vliw_pkg::SIZE_LSB +: 2]))
            vliw_pkg::sz_byte: return vliw_pkg::BE_BYTE << a;
            vliw_pkg::sz_half: return vliw_pkg::BE_HALF << {a[1], 1'h0};
            default:           return vliw_pkg::BE_WORD;
        endcase
    endfunction : be_of

    // fetch and execute-packet split
    always_comb begin
        state_next     = state_reg;
        pc_next        = pc_reg;
        ptr_next       = ptr_reg;
        pkt_next       = pkt_reg;
        fetch_req_next = 1'h0;
        in_pkt         = '0;
        ended          = 1'h0;
        last           = ptr_reg;
        case (state_reg)
            vliw_pkg::st_fetch: begin
                fetch_req_next = 1'h1;
                state_next     = vliw_pkg::st_wait;
            end
            vliw_pkg::st_wait: begin
                if (fetch_valid) begin
                    pkt_next   = fetch_data;
                    ptr_next   = '0;
                    state_next = vliw_pkg::st_issue;
                end
            end
            vliw_pkg::st_issue: begin
                for (int i = 0; i < SLOTS; i++) begin
                    if (PTR_W'(i) >= ptr_reg && !ended) begin
                        in_pkt[i] = 1'h1;
                        if (!pkt_reg[i][vliw_pkg::CHAIN_BIT] ||
                            i == SLOTS - 1) begin
                            ended = 1'h1;
                            last  = PTR_W'(i);
                        end
                    end
                end
                if (last == PTR_W'(SLOTS - 1)) begin
                    state_next = vliw_pkg::st_fetch;
                    pc_next    = pc_reg + vliw_pkg::FETCH_BYTES;
                end else begin
                    ptr_next = last + PTR_W'(1);
                end
            end
            default: state_next = vliw_pkg::st_fetch;
        endcase
    end

    // routing of one execute packet to its units
    always_comb begin
        iv_next = '0;
        ii_next = '0;
        oa_next = '0;
        ob_next = '0;
        mr_next = '0;
        ma_next = '0;
        mb_next = '0;
        md_next = '0;
        mx_next = '0;
        err_next = 1'h0;
        pi_next = state_reg == vliw_pkg::st_issue;
        taken = '0;
        xrd = '0;
        w = '0;
        u = vliw_pkg::logic_unit_side_a;
        sd = 1'h0;
        cm = '0;
        cv = '0;
        xs = 1'h0;
        ok = 1'h0;
        pass = 1'h0;
        s1v = '0;
        s2v = '0;
        ba = '0;
        ea = '0;
        for (int i = 0; i < SLOTS; i++) begin
            w  = pkt_reg[i];
            u  = unit_of(w);
            sd = u[vliw_pkg::SIDE_BIT];
            cm = creg_map(w[vliw_pkg::CREG_LSB +: vliw_pkg::CREG_W]);
            cv = cm[4] ? rf_b_reg[cm[3:0]] : rf_a_reg[cm[3:0]];
            xs = w[vliw_pkg::CROSS_BIT] && !is_long(w) &&
                 vliw_pkg::class_t'(w[vliw_pkg::CLASS_LSB +: 2])
                 != vliw_pkg::cls_mem;
            s1v = sd ? rf_b_reg[w[vliw_pkg::SRC1_LSB +: IW]]
                     : rf_a_reg[w[vliw_pkg::SRC1_LSB +: IW]];
            s2v = (sd ^ xs) ? rf_b_reg[w[vliw_pkg::SRC2_LSB +: IW]]
                            : rf_a_reg[w[vliw_pkg::SRC2_LSB +: IW]];
            if (in_pkt[i] && state_reg == vliw_pkg::st_issue) begin
                if (taken[u]) begin
                    err_next = 1'h1;
                end else begin
                    taken[u] = 1'h1;
                    ok = legal(w) && !(xs && xrd[sd]);
                    if (xs)
                        xrd[sd] = 1'h1;
                    if (!ok)
                        err_next = 1'h1;
                    pass = cm[5] ||
                           (w[vliw_pkg::Z_BIT] ? cv == '0 : cv != '0);
                    ii_next[u] = w;
                    oa_next[u] = s1v;
                    ob_next[u] = s2v;
                    iv_next[u] = ok && pass;
                    if (ok && pass && vliw_pkg::class_t'(
                        w[vliw_pkg::CLASS_LSB +: 2]) == vliw_pkg::cls_mem) begin
                        ba = !is_long(w) ? s1v :
                             sd ? rf_b_reg[vliw_pkg::LONG_BASE]
                                : rf_a_reg[vliw_pkg::LONG_BASE];
                        ea = addr_of(w, ba);
                        mr_next[sd] = 1'h1;
                        ma_next[sd] = ea;
                        mb_next[sd] = be_of(w, ea[1:0]);
                        md_next[sd] = vliw_pkg::size_t'(
                            w[vliw_pkg::SIZE_LSB +: 2])
                            == vliw_pkg::double_word_load;
                        mx_next[sd] = w[vliw_pkg::CROSS_BIT];
                    end
                end
            end
        end
    end

    // register file write-back
    always_comb begin
        rfa_next  = rf_a_reg;
        rfb_next  = rf_b_reg;
        xw        = '0;
        drop_next = 1'h0;
        uu = '0;
        us = 1'h0;
        ds = 1'h0;
        pr = 1'h0;
        wd = '0;
        for (int k = 0; k < SLOTS; k++) begin
            uu = 3'(k);
            us = uu[vliw_pkg::SIDE_BIT];
            ds = us ^ wb_xside[k];
            wd = wb_dst[k*IW +: IW];
            pr = wb_pair[k] &&
                 (vliw_pkg::unit_t'(uu) == vliw_pkg::shift_unit_side_a ||
                  vliw_pkg::unit_t'(uu) == vliw_pkg::shift_unit_side_b);
            if (wb_en[k]) begin
                if ((wb_xside[k] && xw[us]) || (wb_pair[k] && !pr)) begin
                    drop_next = 1'h1;
                end else begin
                    if (wb_xside[k])
                        xw[us] = 1'h1;
                    if (pr) begin
                        wd = wd & ~vliw_pkg::PAIR_MASK;
                        if (ds)
                            rfb_next[wd | vliw_pkg::PAIR_MASK] =
                                wb_data[k*vliw_pkg::DW_W + RW +: RW];
                        else
                            rfa_next[wd | vliw_pkg::PAIR_MASK] =
                                wb_data[k*vliw_pkg::DW_W + RW +: RW];
                    end
                    if (ds)
                        rfb_next[wd] = wb_data[k*vliw_pkg::DW_W +: RW];
                    else
                        rfa_next[wd] = wb_data[k*vliw_pkg::DW_W +: RW];
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg     <= vliw_pkg::st_fetch;
            pc_reg        <= RESET_PC;
            ptr_reg       <= '0;
            pkt_reg       <= '0;
            fetch_req_reg <= 1'h0;
            pi_reg        <= 1'h0;
            iv_reg        <= '0;
            ii_reg        <= '0;
            oa_reg        <= '0;
            ob_reg        <= '0;
            err_reg       <= 1'h0;
            mr_reg        <= '0;
            ma_reg        <= '0;
            mb_reg        <= '0;
            md_reg        <= '0;
            mx_reg        <= '0;
            drop_reg      <= 1'h0;
            for (int r = 0; r < vliw_pkg::REGS; r++) begin
                rf_a_reg[r] <= '0;
                rf_b_reg[r] <= '0;
            end
        end else begin
            state_reg     <= state_next;
            pc_reg        <= pc_next;
            ptr_reg       <= ptr_next;
            pkt_reg       <= pkt_next;
            fetch_req_reg <= fetch_req_next;
            pi_reg        <= pi_next;
            iv_reg        <= iv_next;
            ii_reg        <= ii_next;
            oa_reg        <= oa_next;
            ob_reg        <= ob_next;
            err_reg       <= err_next;
            mr_reg        <= mr_next;
            ma_reg        <= ma_next;
            mb_reg        <= mb_next;
            md_reg        <= md_next;
            mx_reg        <= mx_next;
            drop_reg      <= drop_next;
            rf_a_reg      <= rfa_next;
            rf_b_reg      <= rfb_next;
        end
    end

    assign fetch_req    = fetch_req_reg;
    assign fetch_addr   = pc_reg;
    assign pkt_issued   = pi_reg;
    assign issue_valid  = iv_reg;
    assign issue_instr  = ii_reg;
    assign issue_opa    = oa_reg;
    assign issue_opb    = ob_reg;
    assign decode_error = err_reg;
    assign mem_req      = mr_reg;
    assign mem_addr     = ma_reg;
    assign mem_be       = mb_reg;
    assign mem_dword    = md_reg;
    assign mem_xside    = mx_reg;
    assign wb_dropped   = drop_reg;
endmodule : vliw_fetch_dispatch
`default_nettype wire

/* tb/vliw_fetch_dispatch_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module vliw_fetch_dispatch_chk (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        fetch_req,
    input wire logic [31:0] fetch_addr,
    input wire logic        fetch_valid,
    input wire logic        pkt_issued,
    input wire logic [7:0]  issue_valid,
    input wire logic        decode_error,
    input wire logic [1:0]  mem_req,
    input wire logic [7:0]  wb_en,
    input wire logic        wb_dropped
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_fetch_one_pulse: assert property (fetch_req |=> !fetch_req)
        else $error("fetch request longer than one cycle");
    a_fetch_addr_aligned: assert property (
        fetch_req |-> fetch_addr[4:0] == 5'h00)
        else $error("fetch address not aligned");
    a_no_issue_fetch: assert property (
        fetch_req |-> !pkt_issued ##1 !pkt_issued)
        else $error("issue while fetching");
    a_issue_after_valid: assert property (
        $rose(pkt_issued) |-> $past(fetch_valid, 2))
        else $error("first packet not two cycles after data");
    a_wait_answer: assert property (
        fetch_req ##1 fetch_valid |-> ##2 pkt_issued)
        else $error("no dispatch after fetch data");
    a_addr_steps: assert property (
        $changed(fetch_addr) && !$past(rst)
        |-> fetch_addr == $past(fetch_addr) + 32'h20 && pkt_issued)
        else $error("fetch address step wrong");
    a_quiet_idle: assert property (
        !pkt_issued
        |-> issue_valid == 8'h00 && mem_req == 2'h0 && !decode_error)
        else $error("unit activity without a packet");
    a_packet_bound: assert property (
        pkt_issued [*8] |=> !pkt_issued)
        else $error("more than eight packets in a row");
    a_drop_cause: assert property (
        wb_dropped |-> $past(wb_en) != 8'h00)
        else $error("write-back drop without a write");
endmodule : vliw_fetch_dispatch_chk
bind vliw_fetch_dispatch vliw_fetch_dispatch_chk i_chk (
    .core_clk(core_clk), .rst(rst), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
    .pkt_issued(pkt_issued), .issue_valid(issue_valid),
    .decode_error(decode_error), .mem_req(mem_req), .wb_en(wb_en),
    .wb_dropped(wb_dropped));
`default_nettype wire

/* tb/prog_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
module prog_mem_model (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         fetch_req,
    input  wire logic [7:0]   lat,
    input  wire logic [255:0] pkt,
    output var  logic         fetch_valid,
    output var  logic [255:0] fetch_data
);
    logic [7:0] cnt_reg;
    logic       busy_reg;
    always_ff @(posedge core_clk) begin
        fetch_valid <= 1'b0;
        fetch_data  <= ~fetch_data; // released bus keeps changing
        if (rst) begin
            busy_reg   <= 1'b0;
            cnt_reg    <= 8'h00;
            fetch_data <= 256'h0;
        end else if ((fetch_req && lat == 8'h00) ||
                     (busy_reg && cnt_reg == 8'h00)) begin
            fetch_valid <= 1'b1;
            fetch_data  <= pkt;
            busy_reg    <= 1'b0;
        end else if (fetch_req) begin
            busy_reg <= 1'b1;
            cnt_reg  <= lat - 8'h01;
        end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end
endmodule : prog_mem_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int NPK = 24;
    logic         core_clk, rst, fetch_req, fetch_valid, pkt_issued;
    logic         decode_error, wb_dropped;
    logic [31:0]  fetch_addr, wb_dst, seed, ra, rb;
    logic [255:0] fetch_data, issue_instr, issue_opa, issue_opb, mem_pkt;
    logic [255:0] pk[32];
    logic [7:0]   issue_valid, wb_en, wb_xside, wb_pair, mem_be, lat, em;
    logic [77:0]  mem_all;
    logic [255:0] ev;
    logic [1:0]   mem_req, mem_dword, mem_xside;
    logic [63:0]  mem_addr;
    logic [511:0] wb_data;
    logic [7:0]   q_m[$];
    logic [255:0] q_i[$];
    int           n_fail, tests_run;
    assign mem_pkt = pk[fetch_addr[9:5]];
    assign mem_all = {mem_req, mem_addr, mem_be, mem_dword, mem_xside};
    vliw_fetch_dispatch i_vliw_fetch_dispatch (
        .core_clk(core_clk), .rst(rst), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
        .fetch_data(fetch_data), .pkt_issued(pkt_issued),
        .issue_valid(issue_valid), .issue_instr(issue_instr),
        .issue_opa(issue_opa), .issue_opb(issue_opb),
        .decode_error(decode_error), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_be(mem_be), .mem_dword(mem_dword), .mem_xside(mem_xside),
        .wb_en(wb_en), .wb_dst(wb_dst), .wb_xside(wb_xside),
        .wb_pair(wb_pair), .wb_data(wb_data), .wb_dropped(wb_dropped));
    prog_mem_model i_prog_mem_model (
        .core_clk(core_clk), .rst(rst), .fetch_req(fetch_req), .lat(lat),
        .pkt(mem_pkt), .fetch_valid(fetch_valid), .fetch_data(fetch_data));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [255:0] ex(input logic [7:0] m,
                                        input logic [31:0] a, b);
        logic [255:0] w;
        w = '0;
        for (int u = 0; u < 8; u++)
            if (m[u]) w[32*u +: 32] = (u < 4) ? a : b;
        return w;
    endfunction : ex
    // expected {req, addr, be, dword, xside}; circular ring of 2^8 bytes
    function automatic logic [77:0] mx(input logic [255:0] v);
        logic [31:0] w, b, s;
        logic [77:0] e;
        e = '0;
        for (int d = 0; d < 2; d++) begin
            w = v[96 + 128*d +: 32];
            b = d ? rb : ra;
            s = b + (32'(w[27:23]) << w[8:7]);
            if (w[9]) s = (b & ~32'hFF) | (s & 32'hFF);
            if (w[6:5] == 2'h3) begin
                e[76 + d] = 1'b1;
                e[12 + 32*d +: 32] = s;
                e[4 + 4*d +: 4] = (w[8:7] == 2'h0) ? 4'h1 << s[1:0] :
                                  (w[8:7] == 2'h1) ? 4'h3 << {s[1], 1'b0} :
                                  4'hF;
                e[2 + d] = w[8:7] == 2'h3;
                e[d] = w[1];
            end
        end
        return e;
    endfunction : mx
    task automatic chk(input logic [255:0] g, input logic [255:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic build();
        logic [31:0]  r;
        logic [7:0]   ch, m;
        logic [2:0]   u, pos;
        logic [1:0]   cls;
        logic [255:0] v;
        for (int p = 0; p < 32; p++) begin
            r = rnd();
            ch = {1'b0, (p == 0) ? 7'h7F : (p == 1) ? 7'h00 : r[6:0]};
            pos = 3'h0;
            m = 8'h00;
            v = '0;
            for (int s = 0; s < 8; s++) begin
                u = pos + r[10:8]; // distinct units within one packet
                cls = u[1] ? u[1:0] : 2'h0; // mul on multiply, mem on data
                pk[p][32*s +: 32] = {4'h0, r[19:15], 4'h5, 4'h7, r[14:11],
                                     1'b0, r[22:20], cls, u,
                                     cls[0] & r[23], ch[s]};
                m[u] = 1'b1;
                v[32*u +: 32] = pk[p][32*s +: 32];
                pos = pos + 3'h1;
                if (!ch[s]) begin
                    if (p < NPK) begin
                        q_m.push_back(m);
                        q_i.push_back(v);
                    end
                    pos = 3'h0;
                    m = 8'h00;
                    v = '0;
                end
            end
        end
    endtask : build
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    always @(posedge core_clk) begin
        lat <= 8'(rnd() & 32'h3);
        if (!rst && pkt_issued === 1'b1 && q_m.size() > 0) begin
            em = q_m.pop_front();
            ev = q_i.pop_front();
            chk(issue_valid, em);
            chk(issue_instr & ex(em, '1, '1), ev);
            chk(issue_opa & ex(em, '1, '1), ex(em, ra, rb));
            chk(issue_opb & ex(em, '1, '1), ex(em, ra, rb));
            chk(mem_all, mx(ev));
            chk(decode_error, 1'b0);
        end
    end
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        repeat (NPK * 16 + 100) @(posedge core_clk);
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end
    initial begin
        seed = 32'h0000_0047;
        rst = 1'b1;
        wb_pair = 8'h00;
        wb_en = 8'h00;
        wb_dst = 32'h0;
        wb_xside = 8'h00;
        wb_data = 512'h0;
        n_fail = 0;
        tests_run = 0;
        build();
        ra = rnd();
        rb = rnd();
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        wb_en <= 8'h17;
        wb_xside <= 8'h06;
        wb_dst <= 32'h0005_0995;
        wb_data <= {224'h0, rb, 224'h0, ra};
        @(posedge core_clk);
        wb_en <= 8'h62; // shift units pair-write regs 6 and 7, multiply one refused
        wb_pair <= 8'h62;
        wb_xside <= 8'h00;
        wb_dst <= 32'h0770_0070;
        wb_data <= {128'h0, rb, 224'h0, ra, 96'h0};
        #1 chk(wb_dropped, 1'b1);
        @(posedge core_clk);
        wb_en <= 8'h00;
        #1 chk(wb_dropped, 1'b1);
        $display("test write_back done");
        for (int i = 0; i < 1000 && q_m.size() > 0; i++) @(posedge core_clk);
        chk(q_m.size(), 0);
        $display("test dispatch done");
        stop_test();
    end
endmodule : testbench
`default_nettype wire
